// [hw/rom_page_ram_phase_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: 192k ROM over three devices, 32k RAM.
// R2: ROM selected only in upper half.
// R3: C000-FFFF always third ROM, bits high.
// R4: 8000-BFFF bank chosen by page port.
// R5: Page bits 3:2 pick one ROM select.
// R6: ROM A14/A15 are inverted page bits.
// R7: CPU gets RAM in phases 0, 5.
// R8: CPU buffers on, own drivers off then.
// R9: RAM data always passes through array.
// R10: Port transfers also only phases 0, 5.
// R11: Supply loss raises NMI to processor.
// R12: Processor pulses RAM into standby.
// R13: Array reset held until power-up delay.
// R14: Page 1100-1111 decode like root.
module rom_page_ram_phase_decoder #(
   parameter int POWERUP_CYCLES_P = mem_decode_pkg::POWERUP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Processor bus
   input  wire logic [15:0] cpuAddr,
   input  wire logic        cpuValid,
   input  wire logic        cpuWrite,
   input  wire logic        cpuPortSel,
   input  wire logic [7:0]  cpuWrData,
   output logic [7:0]       cpuRdData,
   output logic             cpuRdValid,
   // Page port and supply
   input  wire logic [3:0]  pageBits,
   input  wire logic        supplyGood,
   input  wire logic        standbyPulse,
   // ROM side
   output logic             rom0_select_n,
   output logic             rom1_select_n,
   output logic             rom2_select_n,
   output logic             rom_addr_bit14,
   output logic             rom_addr_bit15,
   // RAM side
   output logic [14:0]      ramAddr,
   output logic             cpuAddrBufEn,
   output logic             arrayAddrDrvEn,
   output logic             ramSelect_n,
   output logic             ramWrite_n,
   output logic [7:0]       ramWrData,
   output logic             ramDataOe,
   input  wire logic [7:0]  ramRdData,
   // Ports and system
   output logic             portStrobe,
   output logic             nmiReq_n,
   output logic             arrayReset_n,
   output logic [3:0]       phaseOut
);
   import mem_decode_pkg::*;

   // All decoder state except the phase counter lives in one register
   typedef struct packed {
      // Pin synchronisers
      logic [1:0]   goodSync;
      logic [3:0]   pageSync0;
      logic [3:0]   pageSync1;
      logic         sbSync0;
      logic         sbSync1;

      // ROM side
      logic         rom0N;
      logic         rom1N;
      logic         rom2N;
      logic         a14;
      logic         a15;

      // RAM side
      logic [14:0]  ramAddr;
      logic         cpuBuf;
      logic         arrDrv;
      logic         ramSelN;
      logic         ramWrN;
      logic [7:0]   wrData;
      logic         dataOe;

      // Processor return, ports and supply
      logic [7:0]   rdData;
      logic         rdValid;
      logic         portStb;
      logic         nmiN;
      logic         standby;
      logic         arrRstN;
      power_state_t pwr;
      logic [31:0]  count;
      logic [3:0]   phase;
   } dec_state_t;

   dec_state_t  s_q;
   dec_state_t  s_d;
   logic [3:0]  phase;
   logic        cpuPhase;

   // Phase counter of the ten-phase cycle
   phase_sequencer u_seq (
      .clk      (clk),
      .arst_n   (arst_n),
      .phase    (phase),
      .cpuPhase (cpuPhase)
   );

   // ROM decode for one address and page value
   function automatic logic [4:0] romDecode(input logic [15:0] a,
                                            input logic [3:0]  p);
      logic [4:0] r;
      r = 5'h1F;                                // {rom0,rom1,rom2,a14,a15}
      if (a[15]) begin                          // see R2
         // Root window ignores the page port
         if (a[15:14] == ROOT_WIN) begin
            r = 5'b11011;                       // see R3
         end else if (p[3:2] == ROM_SEL_0) begin
            r = {3'b011, ~p[0], ~p[1]};         // see R4, R5, R6
         end else if (p[3:2] == ROM_SEL_1) begin
            r = {3'b101, ~p[0], ~p[1]};         // see R5, R6
         end else if (p[3:2] == ROM_SEL_2) begin
            r = {3'b110, ~p[0], ~p[1]};         // see R5, R6
         end else begin
            // Page bits 3:2 of 11 are unassigned; fall back to root
            r = 5'b11011;                       // see R14
         end
      end
      return r;
   endfunction

   // Slot grant shared by RAM and port requests
   function automatic logic slotGrant(input logic slot,
                                      input logic valid,
                                      input logic portSel,
                                      input logic wantPort);
      logic g;
      g = slot && valid && (portSel == wantPort);
      return g;
   endfunction

   // Next state of decode, RAM slotting and supply sequencing
   always_comb begin
      logic [4:0] rom;
      logic       ramHit;
      rom = 5'h1F;
      ramHit = 1'b0;
      s_d = s_q;
      // Pins from the board pass two flops before use
      s_d.goodSync  = {s_q.goodSync[0], supplyGood};
      s_d.pageSync0 = pageBits;
      s_d.pageSync1 = s_q.pageSync0;
      s_d.sbSync0   = standbyPulse;
      s_d.sbSync1   = s_q.sbSync0;
      s_d.phase     = phase;

      // ROM selects follow the request one clock later
      rom = romDecode(cpuAddr, s_q.pageSync1);
      if (!cpuValid || cpuPortSel) begin
         rom = 5'h1F;
      end
      s_d.rom0N = rom[4];
      s_d.rom1N = rom[3];
      s_d.rom2N = rom[2];
      s_d.a14   = rom[1];
      s_d.a15   = rom[0];

      // 32k RAM sits in the lower half of the map
      ramHit = cpuValid && !cpuPortSel && !cpuAddr[15];      // see R1
      s_d.cpuBuf  = cpuPhase;                                // see R8
      s_d.arrDrv  = !cpuPhase;                               // see R8
      s_d.ramAddr = cpuAddr[14:0];
      s_d.ramSelN = 1'b1;
      s_d.ramWrN  = 1'b1;
      s_d.dataOe  = 1'b0;
      s_d.rdValid = 1'b0;
      s_d.portStb = 1'b0;
      // Accesses outside the slots wait; the processor holds its request
      if (slotGrant(cpuPhase, ramHit, 1'b0, 1'b0) &&
          !s_q.standby) begin                                // see R7
         s_d.ramSelN = 1'b0;
         s_d.ramWrN  = !cpuWrite;
         s_d.wrData  = cpuWrData;                            // see R9
         s_d.dataOe  = cpuWrite;
      end
      // Port strobes repeat in every slot while the request is held
      if (slotGrant(cpuPhase, cpuValid, cpuPortSel, 1'b1)) begin
         s_d.portStb = 1'b1;                                 // see R10
      end
      // Read data is latched one cycle after the slot, never bypassed
      if (!s_q.ramSelN && s_q.ramWrN) begin
         s_d.rdData  = ramRdData;                            // see R9
         s_d.rdValid = 1'b1;
      end

      // Supply loss requests NMI; the processor pulse arms standby
      s_d.nmiN = s_q.goodSync[1];                            // see R11
      if (s_q.sbSync1) begin
         s_d.standby = 1'b1;                                 // see R12
      end

      case (s_q.pwr)
         PWR_DOWN: begin
            // Array held while the synchronised supply is bad
            s_d.arrRstN = 1'b0;
            s_d.count   = '0;
            if (s_q.goodSync[1]) begin
               s_d.pwr = PWR_SETTLE;
            end
         end
         PWR_SETTLE: begin
            // Settle count runs with the array still held
            s_d.arrRstN = 1'b0;                              // see R13
            if (!s_q.goodSync[1]) begin
               s_d.pwr = PWR_DOWN;
            end else if (s_q.count >= 32'(POWERUP_CYCLES_P - 1)) begin
               s_d.pwr     = PWR_RUN;
               s_d.arrRstN = 1'b1;                           // see R13
               // A standby request in this same cycle still wins
               s_d.standby = s_q.sbSync1;
            end else begin
               s_d.count = s_q.count + 32'd1;
            end
         end
         PWR_RUN: begin
            // Any supply loss re-arms the hold
            if (!s_q.goodSync[1]) begin
               s_d.pwr = PWR_DOWN;
            end
         end
         default: begin
            // Unused code falls back to the safe state
            s_d.pwr = PWR_DOWN;
         end
      endcase
   end

   // Reset values: ROMs and RAM idle, array held in reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Supply synchroniser starts at the good level: no false NMI
         s_q.goodSync  <= '1;
         s_q.pageSync0 <= PAGE_RESET;
         s_q.pageSync1 <= PAGE_RESET;
         s_q.sbSync0   <= 1'b0;
         s_q.sbSync1   <= 1'b0;
         // ROM side idle
         s_q.rom0N     <= 1'b1;
         s_q.rom1N     <= 1'b1;
         s_q.rom2N     <= 1'b1;
         s_q.a14       <= 1'b1;
         s_q.a15       <= 1'b1;
         // RAM side idle, gate array owns the address bus
         s_q.ramAddr   <= '0;
         s_q.cpuBuf    <= 1'b0;
         s_q.arrDrv    <= 1'b1;
         s_q.ramSelN   <= 1'b1;
         s_q.ramWrN    <= 1'b1;
         s_q.wrData    <= '0;
         s_q.dataOe    <= 1'b0;
         // Processor return and port strobe quiet
         s_q.rdData    <= '0;
         s_q.rdValid   <= 1'b0;
         s_q.portStb   <= 1'b0;
         // Supply sequencing, array held in reset
         s_q.nmiN      <= 1'b1;
         s_q.standby   <= 1'b0;
         s_q.arrRstN   <= 1'b0;
         s_q.pwr       <= PWR_DOWN;
         s_q.count     <= '0;
         s_q.phase     <= PHASE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Processor read return
   assign cpuRdData      = s_q.rdData;
   assign cpuRdValid     = s_q.rdValid;

   // ROM side
   assign rom0_select_n  = s_q.rom0N;
   assign rom1_select_n  = s_q.rom1N;
   assign rom2_select_n  = s_q.rom2N;
   assign rom_addr_bit14 = s_q.a14;
   assign rom_addr_bit15 = s_q.a15;

   // RAM side
   assign ramAddr        = s_q.ramAddr;
   assign cpuAddrBufEn   = s_q.cpuBuf;
   assign arrayAddrDrvEn = s_q.arrDrv;
   assign ramSelect_n    = s_q.ramSelN;
   assign ramWrite_n     = s_q.ramWrN;
   assign ramWrData      = s_q.wrData;
   assign ramDataOe      = s_q.dataOe;

   // Ports and system
   assign portStrobe     = s_q.portStb;
   assign nmiReq_n       = s_q.nmiN;
   assign arrayReset_n   = s_q.arrRstN;
   assign phaseOut       = s_q.phase;

endmodule // rom_page_ram_phase_decoder
`default_nettype wire

// [hw/mem_decode_pkg.sv]
package mem_decode_pkg;

   // Address windows, upper two address bits
   localparam logic [1:0]  ROOT_WIN         = 2'h3;  // C000-FFFF
   localparam logic [1:0]  PAGE_WIN         = 2'h2;  // 8000-BFFF
   // Ten-phase system cycle
   localparam int          PHASE_COUNT      = 10;
   localparam logic [3:0]  PHASE_LAST       = 4'h9;
   localparam logic [3:0]  CPU_PHASE_A      = 4'h0;
   localparam logic [3:0]  CPU_PHASE_B      = 4'h5;
   localparam logic [3:0]  PHASE_RESET      = 4'h0;
   // Page port values; page bits 3:2 choose the ROM
   localparam logic [1:0]  ROM_SEL_0        = 2'h0;
   localparam logic [1:0]  ROM_SEL_1        = 2'h1;
   localparam logic [1:0]  ROM_SEL_2        = 2'h2;
   localparam logic [3:0]  PAGE_RESET       = 4'h8;
   // Supply monitoring: settle after supply good in microseconds, standby pulse in nanoseconds
   localparam int          POWERUP_DELAY_US = 100;
   localparam int          CLK_MHZ          = 100;
   localparam int          POWERUP_CYCLES   = POWERUP_DELAY_US * CLK_MHZ;
   localparam int          STANDBY_PULSE_NS = 1000;
   localparam int          STANDBY_CYCLES   = STANDBY_PULSE_NS / 10;

   typedef enum logic [1:0] {
      PWR_DOWN    = 2'b00,
      PWR_SETTLE  = 2'b01,
      PWR_RUN     = 2'b10
   } power_state_t;

endpackage

// [hw/phase_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
// Ten-phase system cycle counter, phase 0 first after reset
module phase_sequencer (
   input  wire logic       clk,
   input  wire logic       arst_n,
   output logic [3:0]      phase,
   output logic            cpuPhase
);
   import mem_decode_pkg::*;

   typedef struct packed {
      logic [3:0] phase;
   } seq_state_t;

   seq_state_t state_q;
   seq_state_t state_d;

   // Wrap after the last phase
   always_comb begin
      state_d = state_q;
      if (state_q.phase == PHASE_LAST) begin
         state_d.phase = PHASE_RESET;
      end else begin
         state_d.phase = state_q.phase + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign phase    = state_q.phase;
   // Processor slots of the cycle
   assign cpuPhase = (state_q.phase == CPU_PHASE_A) ||
                     (state_q.phase == CPU_PHASE_B);   // see R7

endmodule // phase_sequencer
`default_nettype wire

// [tb/decoder_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module decoder_properties #(
   parameter int POWERUP_CYCLES_P = 8
) (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [15:0] cpuAddr,
   input wire logic        cpuValid,
   input wire logic        cpuPortSel,
   input wire logic        supplyGood,
   input wire logic        rom0_select_n,
   input wire logic        rom1_select_n,
   input wire logic        rom2_select_n,
   input wire logic        rom_addr_bit14,
   input wire logic        rom_addr_bit15,
   input wire logic        cpuAddrBufEn,
   input wire logic        arrayAddrDrvEn,
   input wire logic        ramSelect_n,
   input wire logic        portStrobe,
   input wire logic        nmiReq_n,
   input wire logic        arrayReset_n,
   input wire logic [3:0]  phaseOut
);
   import mem_decode_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Shorthands for the request and the processor slot
   wire       romReq = cpuValid && !cpuPortSel;
   wire       inSlot = phaseOut == CPU_PHASE_A || phaseOut == CPU_PHASE_B;
   wire [2:0] romSel_n = {rom2_select_n, rom1_select_n, rom0_select_n};
   // Supply-good run length; saturates so a long run never wraps
   int goodCnt_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) goodCnt_q <= 0;
      else if (!supplyGood) goodCnt_q <= 0;
      else if (goodCnt_q < 4096) goodCnt_q <= goodCnt_q + 1;
   end
   a_root_window: assert property (romReq && cpuAddr[15:14] == ROOT_WIN |=>
      romSel_n == 3'h3 && rom_addr_bit14 && rom_addr_bit15) else $error("root");
   a_low_half: assert property (romReq && !cpuAddr[15] |=> romSel_n == 3'h7)
      else $error("low half selected a ROM");
   a_single_rom: assert property ($countones(romSel_n) >= 2)
      else $error("two ROM selects low");
   a_bus_exclusive: assert property (cpuAddrBufEn != arrayAddrDrvEn)
      else $error("address drivers overlap");
   a_ram_slot: assert property (!ramSelect_n |-> inSlot && cpuAddrBufEn)
      else $error("RAM cycle outside slot");
   a_port_slot: assert property (portStrobe |-> inSlot)
      else $error("port strobe outside slot");
   a_nmi_raise: assert property ($fell(supplyGood) |-> ##[1:4] !nmiReq_n)
      else $error("no interrupt on supply loss");
   a_reset_hold: assert property ($rose(arrayReset_n) |->
      supplyGood && goodCnt_q >= POWERUP_CYCLES_P) else $error("early release");
   c_root: cover property (romReq && cpuAddr[15:14] == ROOT_WIN);
   c_ram: cover property (!ramSelect_n);
   c_release: cover property ($rose(arrayReset_n));
endmodule  // decoder_properties
bind rom_page_ram_phase_decoder decoder_properties #(
   .POWERUP_CYCLES_P(POWERUP_CYCLES_P)
) u_decoder_properties (.clk, .arst_n, .cpuAddr, .cpuValid, .cpuPortSel,
   .supplyGood, .rom0_select_n, .rom1_select_n, .rom2_select_n, .rom_addr_bit14,
   .rom_addr_bit15, .cpuAddrBufEn, .arrayAddrDrvEn, .ramSelect_n, .portStrobe,
   .nmiReq_n, .arrayReset_n, .phaseOut);
`default_nettype wire

// [tb/ram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ram_model (
   input  wire logic        clk,
   input  wire logic [14:0] ramAddr,
   input  wire logic        ramSelect_n,
   input  wire logic        ramWrite_n,
   input  wire logic [7:0]  ramWrData,
   output logic [7:0]       ramRdData
);
   logic [7:0] mem [0:32767];  // One 32k byte store
   logic [7:0] idle_q = 8'h00;
   // Deselected bus toggles so a stale byte never passes for a read
   always @(posedge clk) begin
      if (!ramSelect_n && !ramWrite_n) mem[ramAddr] <= ramWrData;
      idle_q <= ~ramRdData;
   end
   assign ramRdData = ramSelect_n ? idle_q : mem[ramAddr];
endmodule  // ram_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mem_decode_pkg::*;
   localparam int PWR_P = 8;  // Short settle count keeps the run brief
   logic clk = 1'h0, arst_n = 1'h0, cpuValid = 1'h0, cpuWrite = 1'h0;
   logic cpuPortSel = 1'h0, supplyGood = 1'h1, standbyPulse = 1'h0;
   logic [15:0] cpuAddr = 16'h8000;
   logic [7:0]  cpuWrData = 8'h00, cpuRdData, ramWrData, ramRdData;
   logic [3:0]  pageBits = PAGE_RESET, phaseOut;
   logic [14:0] ramAddr;
   logic cpuRdValid, rom0_select_n, rom1_select_n, rom2_select_n, ramDataOe;
   logic rom_addr_bit14, rom_addr_bit15, cpuAddrBufEn, arrayAddrDrvEn;
   logic ramSelect_n, ramWrite_n, portStrobe, nmiReq_n, arrayReset_n;
   wire [2:0] romSel = {rom2_select_n, rom1_select_n, rom0_select_n};
   wire [1:0] romHi = {rom_addr_bit14, rom_addr_bit15};
   wire inSlot = phaseOut == CPU_PHASE_A || phaseOut == CPU_PHASE_B;
   logic [2:0] sel;
   logic [1:0] ab;
   int bad_count = 0, compares = 0, n;
   rom_page_ram_phase_decoder #(.POWERUP_CYCLES_P(PWR_P))
      u_rom_page_ram_phase_decoder (.clk, .arst_n, .cpuAddr, .cpuValid,
      .cpuWrite, .cpuPortSel, .cpuWrData, .cpuRdData, .cpuRdValid, .pageBits,
      .supplyGood, .standbyPulse, .rom0_select_n, .rom1_select_n,
      .rom2_select_n, .rom_addr_bit14, .rom_addr_bit15, .ramAddr, .cpuAddrBufEn,
      .arrayAddrDrvEn, .ramSelect_n, .ramWrite_n, .ramWrData, .ramDataOe,
      .ramRdData, .portStrobe, .nmiReq_n, .arrayReset_n, .phaseOut);
   ram_model u_ram_model (.clk, .ramAddr, .ramSelect_n, .ramWrite_n,
      .ramWrData, .ramRdData);
   initial forever #5 clk = ~clk;
   task automatic check(input string what, input logic [15:0] exp, got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait; always lets at least one edge pass
   task automatic wait_lvl(ref logic sig, input logic lvl);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (sig === lvl) return;
      end
      check("wait", lvl, sig);
      final_report();
   endtask
   task automatic rom_go(input logic [15:0] a, input logic [3:0] pg);
      @(posedge clk);
      cpuAddr <= a;
      pageBits <= pg;
      cpuValid <= 1'h1;
      repeat (5) @(posedge clk);  // Page pins pass a synchroniser first
      #1;
   endtask
   task automatic ram_go(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      cpuAddr <= a;
      cpuWrite <= wr;
      cpuWrData <= d;
      cpuValid <= 1'h1;
      wait_lvl(ramSelect_n, 1'h0);
      check("slot", 3'h5, {cpuAddrBufEn, arrayAddrDrvEn, inSlot});
      check("ramAddr", a[14:0], ramAddr);
      check("ramCtl", {~wr, wr}, {ramWrite_n, ramDataOe});
      if (wr) check("ramWrData", d, ramWrData);
      @(posedge clk);
      cpuValid <= 1'h0;
      #1;
      if (!wr) check("rdData", {1'h1, d}, {cpuRdValid, cpuRdData});
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      // No interrupt out of reset, array still held
      repeat (3) @(posedge clk) #1
         check("rstIdle", 2'h2, {nmiReq_n, arrayReset_n});
      // Every page value through the banked window
      for (int p = 0; p < 16; p++) begin
         sel = p[3:2] == 0 ? 3'h6 : p[3:2] == 1 ? 3'h5 : 3'h3;
         ab = p[3:2] == 3 ? 2'h3 : {~p[0], ~p[1]};
         rom_go(16'h9000, 4'(p));
         check("bank", {sel, ab}, {romSel, romHi});
      end
      rom_go(16'hC123, 4'h0);
      check("root", 5'h0F, {romSel, romHi});
      rom_go(16'h7FFF, 4'h0);
      check("low", 3'h7, romSel);
      @(posedge clk);
      cpuValid <= 1'h0;
      // Back-to-back RAM slots, both address ends
      ram_go(1'h1, 16'h7FFF, 8'hA5);
      ram_go(1'h1, 16'h0000, 8'h5A);
      ram_go(1'h0, 16'h7FFF, 8'hA5);
      ram_go(1'h0, 16'h0000, 8'h5A);
      @(posedge clk);
      cpuPortSel <= 1'h1;
      cpuValid <= 1'h1;
      wait_lvl(portStrobe, 1'h1);
      check("portSlot", 1'h1, inSlot);
      check("portRam", 1'h1, ramSelect_n);
      // Supply loss: interrupt, the held array reset, then standby
      @(posedge clk);
      cpuValid <= 1'h0;
      cpuPortSel <= 1'h0;
      supplyGood <= 1'h0;
      wait_lvl(nmiReq_n, 1'h0);
      wait_lvl(arrayReset_n, 1'h0);
      @(posedge clk);
      standbyPulse <= 1'h1;
      repeat (3) @(posedge clk);
      standbyPulse <= 1'h0;
      repeat (3) @(posedge clk);
      cpuAddr <= 16'h0040;
      cpuWrite <= 1'h1;
      cpuValid <= 1'h1;
      repeat (12) @(posedge clk) #1 check("standby", 1'h1, ramSelect_n);
      @(posedge clk);
      cpuValid <= 1'h0;
      supplyGood <= 1'h1;
      for (n = 0; n < 40 && arrayReset_n !== 1'h1; n++) @(posedge clk) #1;
      check("holdLen", 1'h1, n >= PWR_P && n <= PWR_P + 6);
      check("nmiBack", 1'h1, nmiReq_n);
      final_report();
   end
endmodule  // tb_top
`default_nettype wire
